//--- logic/frtc_timer.sv
// Free-running 16-bit timer with two compare outputs, Wishbone slave
//
// Overview of operation
// RQ1: Sixteen-bit up-counter advances once per timer tick, read as two bytes.
// RQ2: Two-bit prescale picks system clock over two, four, eight, or external.
// RQ3: Main and alternate views return the same count; differ in flag effects.
// RQ4: Writing either low count byte reloads the counter with fffc.
// RQ5: Reset loads fffc; that is the only reload value.
// RQ6: High byte read first latches low byte until low byte is read.
// RQ7: After a completed pair, a lone low read returns the live byte.
// RQ8: Rollover from ffff to zero sets the overflow flag, any clock choice.
// RQ9: Overflow interrupt only while enabled and processor mask clear; IRQ_O ignores both and follows the overflow event and mask bit.
// RQ10: Overflow flag clears by status read then main low byte access.
// RQ11: Alternate low byte accesses never clear the overflow flag.
// RQ12: Wait mode keeps counting; halt stops and resumes from held count.
// RQ13: Two compare registers, byte split, compared each timer tick.
// RQ14: Match sets flag, drives enabled pin level, requests enabled irq.
// RQ15: Compare registers only software written; reset loads 8000.
// RQ16: Compare high byte write inhibits matching until low byte written.
// RQ17: Channel one match with pin enabled copies its level to pin one.
// RQ18: Force bit copies level to enabled pin, sets no compare flag.
// RQ19: External clock is synchronised; counter advances once per rising edge.
module frtc_timer
    import frtc_pkg::*;
(
    // System
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Power mode and external timer clock
    input wire logic HALT_I,
    input wire logic EXT_CLK_I,
    // Compare output pins
    output logic [1:0] COMPARE_OUTPUT_PIN_O,
    // Interrupts
    output logic TIMER_IRQ_O,
    output logic IRQ_O
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic req;
    logic wr;
    logic rd;
    logic a_cnt_hi;
    logic a_cnt_lo;
    logic a_alt_hi;
    logic a_alt_lo;
    logic a_c1;
    logic a_c2;
    logic a_stat;
    logic a_evt;
    logic a_mask;
    logic a_ok;
    logic [1:0] a_cmp_hi;
    logic [1:0] a_cmp_lo;

    // One request per bus cycle: the cycle before ack rises
    assign req = CYC_I & STB_I & ~ACK_O;
    assign wr = req & WE_I & SEL_I[0];
    assign rd = req & ~WE_I;
    assign a_cnt_hi = ADR_I == FRTC_ADR_CNT_HI;
    assign a_cnt_lo = ADR_I == FRTC_ADR_CNT_LO;
    assign a_alt_hi = ADR_I == FRTC_ADR_ALT_HI;
    assign a_alt_lo = ADR_I == FRTC_ADR_ALT_LO;
    assign a_cmp_hi = {ADR_I == FRTC_ADR_CMP2_HI,
        ADR_I == FRTC_ADR_CMP1_HI};
    assign a_cmp_lo = {ADR_I == FRTC_ADR_CMP2_LO,
        ADR_I == FRTC_ADR_CMP1_LO};
    assign a_c1 = ADR_I == FRTC_ADR_CTRL1;
    assign a_c2 = ADR_I == FRTC_ADR_CTRL2;
    assign a_stat = ADR_I == FRTC_ADR_STAT;
    assign a_evt = ADR_I == FRTC_ADR_EVT;
    assign a_mask = ADR_I == FRTC_ADR_MASK;
    assign a_ok = a_cnt_hi | a_cnt_lo | a_alt_hi | a_alt_lo |
        (|a_cmp_hi) | (|a_cmp_lo) | a_c1 | a_c2 | a_stat | a_evt |
        a_mask;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [15:0] cnt;
    logic [7:0] lo_buf;
    logic latched;
    logic overflow_flag;
    logic tof_armed;
    frtc_ctrl1_t ctrl1;
    frtc_ctrl2_t ctrl2;
    logic [FRTC_EV_W-1:0] evt;
    logic [FRTC_EV_W-1:0] mask;
    logic [15:0] cmp [2];
    logic [1:0] inhibit;
    logic [1:0] ocf;
    logic [1:0] ocf_armed;
    logic [1:0] match;
    logic tick;
    logic run;
    logic reload;
    logic ovf;
    logic tof_clr;
    logic [7:0] st_byte;
    logic [7:0] c1_byte;
    logic [7:0] c2_byte;
    logic [7:0] rd_byte;
    logic [FRTC_EV_W-1:0] next_evt;

    // ****************************************************************
    // Timer clock source
    // ****************************************************************
    frtc_tick u_tick (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .prescale_select_i(ctrl2.prescale_select),
        .ext_clk_i(EXT_CLK_I),
        .tick_o(tick)
    );

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Halt freezes the count; wait mode has no port since it changes
    // nothing here. A reset wake-up goes through the system reset.
    assign run = tick & ~HALT_I; // [RQ12]
    assign reload = wr & (a_cnt_lo | a_alt_lo); // [RQ4]
    assign ovf = run & ~reload & (cnt == FRTC_CNT_TOP); // [RQ8]

    // Reload wins over a tick in the same cycle
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            cnt <= FRTC_CNT_RELOAD; // [RQ5]
        else if (reload)
            cnt <= FRTC_CNT_RELOAD; // [RQ4]
        else if (run)
            cnt <= cnt + 16'h1; // [RQ1]
    end

    // ****************************************************************
    // Low byte latch for two-byte reads
    // ****************************************************************
    // The first high read latches; repeat high reads leave it alone
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            lo_buf <= 8'h00;
            latched <= 1'b0;
        end
        else if (rd & (a_cnt_lo | a_alt_lo))
            latched <= 1'b0; // [RQ7]
        else if (rd & (a_cnt_hi | a_alt_hi) & ~latched)
        begin
            lo_buf <= cnt[7:0]; // [RQ6]
            latched <= 1'b1;
        end
    end

    // ****************************************************************
    // Overflow flag with two-step clear
    // ****************************************************************
    // Only the main low byte finishes the clear, so the alternate view
    // can sample time without losing an overflow
    assign tof_clr = tof_armed & req & a_cnt_lo; // [RQ10] [RQ11]

    // A rollover in the clearing cycle still sets the flag
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            overflow_flag <= 1'b0;
            tof_armed <= 1'b0;
        end
        else
        begin
            overflow_flag <= ovf | (overflow_flag & ~tof_clr); // [RQ8] [RQ10]
            if (tof_clr | ovf)
                tof_armed <= 1'b0;
            else if (rd & a_stat & overflow_flag)
                tof_armed <= 1'b1; // [RQ10]
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl1 <= '0;
            ctrl2 <= '0;
        end
        else
        begin
            if (wr & a_c1)
                ctrl1 <= {DAT_I[FRTC_C1_COMPARE_IRQ_ENABLE], DAT_I[FRTC_C1_OVERFLOW_IRQ_ENABLE],
                    DAT_I[FRTC_C1_FOLV2], DAT_I[FRTC_C1_FOLV1],
                    DAT_I[FRTC_C1_OLVL2], DAT_I[FRTC_C1_OLVL1]};
            if (wr & a_c2)
                ctrl2 <= {DAT_I[FRTC_C2_PIN2], DAT_I[FRTC_C2_PIN1],
                    DAT_I[FRTC_C2_CPUM], DAT_I[1:0]}; // [RQ2]
        end
    end

    // ****************************************************************
    // Compare channels
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_ch
            logic ocf_clr;

            // Match on a running tick unless a half-written value
            // is pending
            assign match[i] = run & (cnt == cmp[i]) &
                ~inhibit[i]; // [RQ13] [RQ16]
            assign ocf_clr = ocf_armed[i] & req & a_cmp_lo[i];

            // Only software writes alter the compare value
            always_ff @(posedge CLK_I)
            begin
                if (SYS_RST_I)
                begin
                    cmp[i] <= FRTC_CMP_RESET; // [RQ15]
                    inhibit[i] <= 1'b0;
                end
                else if (wr & a_cmp_hi[i])
                begin
                    cmp[i][15:8] <= DAT_I[7:0];
                    inhibit[i] <= 1'b1; // [RQ16]
                end
                else if (wr & a_cmp_lo[i])
                begin
                    cmp[i][7:0] <= DAT_I[7:0];
                    inhibit[i] <= 1'b0; // [RQ16]
                end
            end

            // Flag set wins over its two-step clear
            always_ff @(posedge CLK_I)
            begin
                if (SYS_RST_I)
                begin
                    ocf[i] <= 1'b0;
                    ocf_armed[i] <= 1'b0;
                end
                else
                begin
                    ocf[i] <= match[i] | (ocf[i] & ~ocf_clr); // [RQ14]
                    if (ocf_clr | match[i])
                        ocf_armed[i] <= 1'b0;
                    else if (rd & a_stat & ocf[i])
                        ocf_armed[i] <= 1'b1;
                end
            end

            // Pin takes its level on a match or while forced, if enabled;
            // force does not touch the flag
            always_ff @(posedge CLK_I)
            begin
                if (SYS_RST_I)
                    COMPARE_OUTPUT_PIN_O[i] <= 1'b0;
                else if (ctrl2.compare_pin_enable[i] &
                    (match[i] | ctrl1.force_output_level[i]))
                    COMPARE_OUTPUT_PIN_O[i] <=
                        ctrl1.compare_output_level[i]; // [RQ14] [RQ17] [RQ18]
            end
        end
    endgenerate

    // ****************************************************************
    // Event register, mask and interrupt lines
    // ****************************************************************
    // Write one to clear, but a fresh event in the same cycle stays
    assign next_evt = ({match, ovf}) |
        (evt & ~((wr & a_evt) ? DAT_I[FRTC_EV_W-1:0] : '0));

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            evt <= '0;
            mask <= '0;
            IRQ_O <= 1'b0;
            TIMER_IRQ_O <= 1'b0;
        end
        else
        begin
            evt <= next_evt;
            if (wr & a_mask)
                mask <= DAT_I[FRTC_EV_W-1:0];
            IRQ_O <= |(evt & mask);
            // Pending flags wait until enable and processor mask allow
            TIMER_IRQ_O <= ~ctrl2.cpu_irq_mask &
                ((overflow_flag & ctrl1.overflow_irq_enable) | ((|ocf) & ctrl1.compare_irq_enable)); // [RQ9] [RQ14]
        end
    end

    // ****************************************************************
    // Read data and acknowledge
    // ****************************************************************
    assign st_byte = 8'((ocf[0] << FRTC_ST_OCF1) |
        (overflow_flag << FRTC_ST_TOF) | (ocf[1] << FRTC_ST_OCF2));
    assign c1_byte = 8'((ctrl1.compare_irq_enable << FRTC_C1_COMPARE_IRQ_ENABLE) |
        (ctrl1.overflow_irq_enable << FRTC_C1_OVERFLOW_IRQ_ENABLE) |
        (ctrl1.force_output_level[1] << FRTC_C1_FOLV2) |
        (ctrl1.force_output_level[0] << FRTC_C1_FOLV1) |
        (ctrl1.compare_output_level[1] << FRTC_C1_OLVL2) |
        (ctrl1.compare_output_level[0] << FRTC_C1_OLVL1));
    assign c2_byte = 8'((ctrl2.compare_pin_enable[0] << FRTC_C2_PIN1) |
        (ctrl2.compare_pin_enable[1] << FRTC_C2_PIN2) |
        (ctrl2.cpu_irq_mask << FRTC_C2_CPUM) |
        ctrl2.prescale_select);
    // Both views share one count; only flag side effects differ
    assign rd_byte = (a_cnt_hi | a_alt_hi) ? cnt[15:8] : // [RQ3]
        (a_cnt_lo | a_alt_lo) ? (latched ? lo_buf : cnt[7:0]) :
        a_cmp_hi[0] ? cmp[0][15:8] :
        a_cmp_lo[0] ? cmp[0][7:0] :
        a_cmp_hi[1] ? cmp[1][15:8] :
        a_cmp_lo[1] ? cmp[1][7:0] :
        a_c1 ? c1_byte :
        a_c2 ? c2_byte :
        a_stat ? st_byte :
        a_evt ? 8'(evt) :
        a_mask ? 8'(mask) : 8'h00;

    // One wait state; unmapped addresses answer with zero
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0;
        end
        else
        begin
            ACK_O <= req;
            DAT_O <= (rd & a_ok) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // All checks run on the system clock and sleep through reset
    default clocking chk_cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    AST_RELOAD: assert property (reload |=> cnt == FRTC_CNT_RELOAD) // [RQ4]
        else $error("counter not reloaded after low byte write");

    AST_COUNT: assert property ( // [RQ1]
        run & ~reload |=> cnt == 16'($past(cnt) + 16'h1))
        else $error("counter did not advance on tick");

    AST_HALT: assert property (HALT_I & ~reload |=> $stable(cnt)) // [RQ12]
        else $error("counter moved while halted");

    AST_OVF: assert property (ovf |=> overflow_flag && cnt == 16'h0000) // [RQ8]
        else $error("rollover did not set overflow flag");

    AST_ALT_KEEP: assert property (overflow_flag & req & a_alt_lo |=> overflow_flag) // [RQ11]
        else $error("alternate low access cleared overflow flag");

    // A bus master needs an idle cycle between requests, so the main
    // low access comes two cycles after the status read at the soonest;
    // this check takes the access three cycles after the status read
    AST_TOF_CLEAR: assert property ( // [RQ10]
        overflow_flag & rd & a_stat ##1 ~ovf ##1 ~ovf ##1 (req & a_cnt_lo & ~ovf)
        |=> ~overflow_flag)
        else $error("two-step sequence did not clear overflow flag");

    AST_CMP_HOLD: assert property ( // [RQ15]
        ~(wr & ((|a_cmp_hi) | (|a_cmp_lo))) |=> $stable(cmp[0]))
        else $error("compare value changed without a write");

    AST_INHIBIT: assert property ( // [RQ16]
        inhibit[0] |-> ~match[0] ##1 (~ocf[0] || $past(ocf[0])))
        else $error("match taken while compare half written");

    AST_FORCE: assert property ( // [RQ18]
        ctrl1.force_output_level[0] & ctrl2.compare_pin_enable[0]
        |=> COMPARE_OUTPUT_PIN_O[0] == $past(ctrl1.compare_output_level[0]))
        else $error("forced level not copied to pin one");

    AST_IRQ: assert property ( // [RQ9]
        overflow_flag & ctrl1.overflow_irq_enable & ~ctrl2.cpu_irq_mask |=> TIMER_IRQ_O)
        else $error("pending overflow not requested");

    AST_LATCH: assert property ( // [RQ6]
        rd & a_cnt_hi & ~latched ##1 (~(rd & (a_cnt_lo | a_alt_lo)))[*2]
        |-> lo_buf == $past(cnt[7:0], 2))
        else $error("latched low byte changed before low read");

endmodule // frtc_timer

//--- logic/frtc_pkg.sv
// Package: register map, field layout, reset values of the timer
package frtc_pkg;

    // ****************************************************************
    // Register byte addresses on the bus
    // ****************************************************************
    localparam logic [7:0] FRTC_ADR_CNT_HI = 8'h00;
    localparam logic [7:0] FRTC_ADR_CNT_LO = 8'h04;
    localparam logic [7:0] FRTC_ADR_ALT_HI = 8'h08;
    localparam logic [7:0] FRTC_ADR_ALT_LO = 8'h0c;
    localparam logic [7:0] FRTC_ADR_CMP1_HI = 8'h10;
    localparam logic [7:0] FRTC_ADR_CMP1_LO = 8'h14;
    localparam logic [7:0] FRTC_ADR_CMP2_HI = 8'h18;
    localparam logic [7:0] FRTC_ADR_CMP2_LO = 8'h1c;
    localparam logic [7:0] FRTC_ADR_CTRL1 = 8'h20;
    localparam logic [7:0] FRTC_ADR_CTRL2 = 8'h24;
    localparam logic [7:0] FRTC_ADR_STAT = 8'h28;
    localparam logic [7:0] FRTC_ADR_EVT = 8'h2c;
    localparam logic [7:0] FRTC_ADR_MASK = 8'h30;

    // ****************************************************************
    // Reset and reload values
    // ****************************************************************
    localparam logic [15:0] FRTC_CNT_RELOAD = 16'hfffc;
    localparam logic [15:0] FRTC_CNT_TOP = 16'hffff;
    localparam logic [15:0] FRTC_CMP_RESET = 16'h8000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    // Control one: 6 irq enable cmp, 5 irq enable ovf, 4:3 force,
    // 2 level two, 0 level one
    localparam int FRTC_C1_COMPARE_IRQ_ENABLE = 6;
    localparam int FRTC_C1_OVERFLOW_IRQ_ENABLE = 5;
    localparam int FRTC_C1_FOLV2 = 4;
    localparam int FRTC_C1_FOLV1 = 3;
    localparam int FRTC_C1_OLVL2 = 2;
    localparam int FRTC_C1_OLVL1 = 0;
    // Control two: 7 pin one, 6 pin two, 5 cpu mask, 1:0 prescale
    localparam int FRTC_C2_PIN1 = 7;
    localparam int FRTC_C2_PIN2 = 6;
    localparam int FRTC_C2_CPUM = 5;
    // Status: 6 compare one, 5 overflow, 4 compare two
    localparam int FRTC_ST_OCF1 = 6;
    localparam int FRTC_ST_TOF = 5;
    localparam int FRTC_ST_OCF2 = 4;
    // Event and mask bits: 0 overflow, 1 compare one, 2 compare two
    localparam int FRTC_EV_W = 3;

    // ****************************************************************
    // Prescale encodings
    // ****************************************************************
    localparam logic [1:0] FRTC_PS_DIV2 = 2'h0;
    localparam logic [1:0] FRTC_PS_DIV4 = 2'h1;
    localparam logic [1:0] FRTC_PS_DIV8 = 2'h2;
    localparam logic [1:0] FRTC_PS_EXT = 2'h3;

    typedef struct packed {
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic [1:0] force_output_level;
        logic [1:0] compare_output_level;
    } frtc_ctrl1_t;

    typedef struct packed {
        logic [1:0] compare_pin_enable;
        logic cpu_irq_mask;
        logic [1:0] prescale_select;
    } frtc_ctrl2_t;

endpackage

//--- logic/frtc_tick.sv
// Timer clock tick generator: divided system clock or external clock
module frtc_tick
    import frtc_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Selection and external source
    input wire logic [1:0] prescale_select_i,
    input wire logic ext_clk_i,
    // One-cycle tick
    output logic tick_o
);

    // ****************************************************************
    // Divider and external clock synchroniser
    // ****************************************************************
    logic [2:0] div;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic next_tick;

    // Tick on the last phase of the chosen division; external edge
    // is taken only from the second and third stages
    assign next_tick = (prescale_select_i == FRTC_PS_DIV2) ? div[0] :
        (prescale_select_i == FRTC_PS_DIV4) ? (div[1:0] == 2'h3) :
        (prescale_select_i == FRTC_PS_DIV8) ? (div == 3'h7) :
        (ext_s2 & ~ext_s3); // [RQ2] [RQ19]

    // Free running divider, stages, registered tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div <= 3'h0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            tick_o <= 1'b0;
        end
        else
        begin
            div <= div + 3'h1;
            ext_s1 <= ext_clk_i;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            tick_o <= next_tick;
        end
    end

endmodule // frtc_tick

//--- verif/tb_top.sv
// Self-checking bench for the free-running compare timer
module tb_top
    import frtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic halt = 1'b1;
    logic ext = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [1:0] pin;
    logic tirq;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    logic [15:0] c0, c1, dv;
    logic [7:0] q, l1, l2, r1, r2;
    int w, k;
    logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c};
    logic [7:0] rv [14] = '{8'hff, 8'hfc, 8'hff, 8'hfc, 8'h80, 8'h00,
        8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Clock at 20 MHz
    always #25 clk = ~clk;

    frtc_timer i_frtc_timer (
        .CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
        .DAT_O(rdat), .ACK_O(ack), .HALT_I(halt), .EXT_CLK_I(ext),
        .COMPARE_OUTPUT_PIN_O(pin), .TIMER_IRQ_O(tirq), .IRQ_O(irq)
    );

    // ****************************************************************
    // Checking and expectation helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ticks per count for each internal prescale code
    function automatic int div_of(input logic [1:0] ps);
        return 2 << ps;
    endfunction

    // Loose window: the exact phase of the divider is not known
    function automatic logic near(input int got, input int exp);
        return (got >= exp - 3) && (got <= exp + 3);
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************************************
    // Classic Wishbone single cycle, waits for ack under a bound
    // ****************************************************************
    task automatic wb(input logic w_i, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_i;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 16)
            chk(1'b0, 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        wb(1'b0, a, 8'h00, r);
    endtask

    // High byte first so the low byte is latched
    task automatic rdc(output logic [15:0] v);
        rd(FRTC_ADR_CNT_HI, v[15:8]);
        rd(FRTC_ADR_CNT_LO, v[7:0]);
    endtask

    // Watchdog: the whole sequence needs at most about eleven hundred cycles
    initial
    begin
        #(50 * 20000);
        n_errors++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h60a31c7c));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values, counter frozen, unmapped place reads zero
        for (int i = 0; i < 14; i++)
        begin
            rd(ra[i], q);
            chk(q, rv[i]);
        end
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        wr(FRTC_ADR_CMP1_HI, r1);
        wr(FRTC_ADR_CMP1_LO, r2);
        rd(FRTC_ADR_CMP1_HI, q);
        chk(q, r1);
        rd(FRTC_ADR_CMP1_LO, q);
        chk(q, r2);
        // Count rate for each internal divider over a random span
        for (int ps = 0; ps < 3; ps++)
        begin
            wr(FRTC_ADR_CTRL2, 8'(ps));
            w = 64 + $urandom % 128;
            rdc(c0);
            halt <= 1'b0;
            repeat (w) @(posedge clk);
            halt <= 1'b1;
            rdc(c1);
            dv = c1 - c0;
            chk(near(dv, w / div_of(2'(ps))), 1'b1);
        end
        // External source: one count per rising edge
        wr(FRTC_ADR_CTRL2, 8'h03);
        halt <= 1'b0;
        k = 1 + $urandom % 8;
        rdc(c0);
        repeat (k)
        begin
            repeat (8) @(posedge clk);
            ext <= 1'b1;
            repeat (8) @(posedge clk);
            ext <= 1'b0;
        end
        repeat (8) @(posedge clk);
        rdc(c1);
        dv = c1 - c0;
        chk(dv, k);
        // Latched low byte survives a second high read
        wr(FRTC_ADR_CTRL2, 8'h00);
        rd(FRTC_ADR_CNT_HI, q);
        repeat (40) @(posedge clk);
        rd(FRTC_ADR_ALT_HI, q);
        halt <= 1'b1;
        rd(FRTC_ADR_CNT_LO, l1);
        rd(FRTC_ADR_ALT_LO, l2);
        chk(near(8'(l2 - l1), 24), 1'b1);
        rdc(c0);
        repeat (10) @(posedge clk);
        rdc(c1);
        chk(c1, c0);
        chk(c0[7:0], l2);
        // Overflow and compare: pins on, processor mask set
        wr(FRTC_ADR_CMP1_HI, 8'h00);
        wr(FRTC_ADR_CMP1_LO, 8'h20);
        wr(FRTC_ADR_CMP2_HI, 8'h00);
        wr(FRTC_ADR_CTRL2, 8'he0);
        wr(FRTC_ADR_CTRL1, 8'h21);
        wr(FRTC_ADR_MASK, 8'h03);
        wr(FRTC_ADR_ALT_LO, 8'h5a);
        halt <= 1'b0;
        repeat (120) @(posedge clk);
        halt <= 1'b1;
        wr(FRTC_ADR_STAT, 8'h00);
        rd(FRTC_ADR_STAT, q);
        chk(q, 8'h60);
        chk(pin, 2'b01);
        chk(tirq, 1'b0);
        chk(irq, 1'b1);
        wr(FRTC_ADR_CTRL2, 8'hc0);
        repeat (3) @(posedge clk);
        chk(tirq, 1'b1);
        rd(FRTC_ADR_ALT_LO, q);
        rd(FRTC_ADR_STAT, q);
        chk(q, 8'h60);
        rd(FRTC_ADR_CNT_LO, q);
        rd(FRTC_ADR_STAT, q);
        chk(q, 8'h40);
        repeat (3) @(posedge clk);
        chk(tirq, 1'b0);
        rd(FRTC_ADR_EVT, q);
        chk(q, 8'h03);
        wr(FRTC_ADR_EVT, 8'h03);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        // Forced level on channel two, no flag set
        wr(FRTC_ADR_CTRL1, 8'h14);
        repeat (3) @(posedge clk);
        chk(pin, 2'b11);
        rd(FRTC_ADR_STAT, q);
        chk(q & 8'h10, 8'h00);
        wrap_up();
    end
endmodule // tb_top
